// [pkg/csu_regs.svh]
// Purpose: constants for the clocked serial unit
// Assumes: included by the design modules by bare name
// Notes:   half period unit is in base sample clock cycles, monitor delays in tenths of a cycle
`ifndef CSU_REGS_SVH
`define CSU_REGS_SVH

// data and bit counting
`define CSU_BYTE_W        8
`define CSU_LAST_BIT      3'h7
`define CSU_FIRST_BIT     3'h0

// master clock divider: half period = (rate select + 1) * unit
`define CSU_HALF_UNIT     7'h04

// monitor delay after releasing scl, printed in tenths of a cycle
`define CSU_MON_00_TENTHS 10'h04B
`define CSU_MON_01_TENTHS 10'h0C3
`define CSU_MON_10_TENTHS 10'h0AF
`define CSU_MON_11_TENTHS 10'h19F
`define CSU_TENTHS_PER_CYC 10'h00A
`define CSU_CKS_MON_HI    3
`define CSU_CKS_MON_LO    2

// reset values
`define CSU_LINE_RST      1'b1
`define CSU_TX_EMPTY_RST  1'b0
`define CSU_BYTE_RST      8'h00

`endif

// [pkg/csu_pkg.sv]
// Purpose: shared types of the clocked serial unit
// Assumes: nothing
// Notes:   control bits travel as one struct
package csu_pkg;

   typedef logic [7:0] csu_byte_t;

   typedef struct packed {
      logic       format_select;
      logic       clock_master_select;
      logic       bit_order_select;
      logic       sda_idle_level;
      logic       transfer_enable_bit;
      logic [3:0] clock_rate_select;
      logic       direction_select;
      logic       receive_stop_request;
      logic       function_select_bit;
   } csu_ctrl_s;

   typedef struct packed {
      logic scl;
      logic sda;
   } csu_pins_s;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_LOW  = 4'h2,
      ST_WAIT = 4'h4,
      ST_HIGH = 4'h8
   } csu_st_e;

endpackage : csu_pkg

// [verilog/csu_filter.sv]
// Purpose: two-latch match filter on one pin
// Assumes: pin is asynchronous to i_mclk
// Notes:   synchroniser first, then the latch pair
`timescale 1ns/10ps
`include "csu_regs.svh"
module csu_filter
   import csu_pkg::*;
(
   // clock and reset
   input  wire logic i_mclk,
   input  wire logic i_rst_n,
   // pin and filtered level
   input  wire logic i_pin,
   output logic      o_level
);

   logic sync1_q, sync2_q, lat1_q, lat2_q, lvl_q;
   wire  latch_match = (lat1_q == lat2_q);
   wire  lvl_d       = latch_match ? lat2_q : lvl_q;

   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         sync1_q <= `CSU_LINE_RST;
         sync2_q <= `CSU_LINE_RST;
         lat1_q  <= `CSU_LINE_RST;
         lat2_q  <= `CSU_LINE_RST;
         lvl_q   <= `CSU_LINE_RST;
      end
      else
      begin
         sync1_q <= i_pin;
         sync2_q <= sync1_q;
         lat1_q  <= sync2_q;
         lat2_q  <= lat1_q;
         lvl_q   <= lvl_d;
      end
   end

   assign o_level = lvl_q;

   filter_hold_a : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (lat1_q != lat2_q) |=> $stable(o_level))
      else $error("filter level moved while latches disagree");

endmodule : csu_filter

// [verilog/csu_link.sv]
// Purpose: shifter on the external transfer clock
// Assumes: scl idles high, each byte is eight clocks
// Notes:   words cross to the system side by toggles
`timescale 1ns/10ps
`include "csu_regs.svh"
module csu_link
   import csu_pkg::*;
(
   // link clock and reset
   input  wire logic      i_scl_clk,
   input  wire logic      i_rst_n,
   // link data pin
   input  wire logic      i_sda,
   // transmit hand-over
   input  wire csu_byte_t i_tx_word,
   input  wire logic      i_tx_req,
   output logic           o_tx_ack,
   // receive hand-over
   output csu_byte_t      o_rx_word,
   output logic           o_rx_tgl,
   // data output
   output logic           o_sda_bit,
   output logic           o_sda_en
);

   logic      req_s1_q, req_s2_q, ack_q, send_q, rx_tgl_q;
   logic [2:0] cnt_q;
   csu_byte_t tx_sh_q, rx_sh_q, rx_word_q;
   wire       boundary  = (cnt_q == `CSU_FIRST_BIT);
   wire       want_load = boundary && (req_s2_q != ack_q);

   // rising edge: sample data, count bits
   always_ff @(posedge i_scl_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         req_s1_q  <= 1'b0;
         req_s2_q  <= 1'b0;
         cnt_q     <= `CSU_FIRST_BIT;
         rx_sh_q   <= `CSU_BYTE_RST;
         rx_word_q <= `CSU_BYTE_RST;
         rx_tgl_q  <= 1'b0;
      end
      else
      begin
         req_s1_q <= i_tx_req;
         req_s2_q <= req_s1_q;
         rx_sh_q  <= {rx_sh_q[6:0], i_sda};
         cnt_q    <= cnt_q + 3'h1;
         if (cnt_q == `CSU_LAST_BIT)
         begin
            rx_word_q <= {rx_sh_q[6:0], i_sda};
            rx_tgl_q  <= ~rx_tgl_q;
         end
      end
   end

   // falling edge: present next bit
   always_ff @(negedge i_scl_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         tx_sh_q <= `CSU_BYTE_RST;
         ack_q   <= 1'b0;
         send_q  <= 1'b0;
      end
      else if (want_load)
      begin
         tx_sh_q <= i_tx_word;
         ack_q   <= req_s2_q;
         send_q  <= 1'b1;
      end
      else if (boundary)
         send_q  <= 1'b0;
      else
         tx_sh_q <= {tx_sh_q[6:0], 1'b0};
   end

   assign o_tx_ack  = ack_q;
   assign o_rx_word = rx_word_q;
   assign o_rx_tgl  = rx_tgl_q;
   assign o_sda_bit = tx_sh_q[7];
   assign o_sda_en  = send_q;

endmodule : csu_link

// [verilog/csu_top.sv]
// Purpose: clocked serial mode of the two-wire unit
// Assumes: open-drain scl and sda resolved outside
// Notes:   master engine on i_mclk, slave shifter on i_scl_clk
//
// How it works
// - format select at 1 picks clocked serial framing.
// - clock master select 1 drives scl; 0 takes scl from outside.
// - data changes after falling scl edges, sampled on rising edges.
// - bit order select picks msb-first or lsb-first shifting.
// - idle sda is driven at the sda idle level bit except in slave receive.
// - setting direction to transmit sets transmit buffer empty.
// - holding byte moves to shifter and sets transmit buffer empty.
// - master select in receive mode starts the receive clock.
// - finished byte goes to receive holding and sets receive full.
// - master receive keeps clocking bytes without software action.
// - byte end while receive full flags overrun, keeps old byte.
// - stop request plus read parks scl high after next byte.
// - the master engine sees each pin through a two-latch match filter on the sample clock; the slave shifter takes raw sda.
// - master waits for scl to really rise before the high phase.
// - monitor delay is 7.5, 19.5, 17.5 or 41.5 cycles by rate bits 3:2; the code counts them rounded up to 8, 20, 18 or 42.
// - writing transmit holding clears transmit buffer empty.
// - reading receive holding clears receive full at once.
`timescale 1ns/10ps
`include "csu_regs.svh"
module csu_top
   import csu_pkg::*;
(
   // clocks and reset
   input  wire logic      i_mclk,
   input  wire logic      i_rst_n,
   input  wire logic      i_scl_clk,
   // control bits
   input  wire csu_ctrl_s i_ctrl,
   input  wire logic      i_lost_clr,
   // software data access
   input  wire logic      i_tx_wr,
   input  wire csu_byte_t i_tx_data,
   input  wire logic      i_rx_rd,
   // pins in
   input  wire csu_pins_s i_pins,
   // pins out
   output logic           o_scl_out,
   output logic           o_scl_oe,
   output logic           o_sda_out,
   output logic           o_sda_oe,
   // status
   output logic           o_tx_buffer_empty,
   output logic           o_rx_buffer_full,
   output logic           o_lost_overrun_flag,
   output csu_byte_t      o_rx_data,
   output logic           o_busy
);

   function automatic csu_byte_t rev8(input csu_byte_t v);
      csu_byte_t r;
      r = v;
      for (int i = 0; i < `CSU_BYTE_W; i++)
         r[i] = v[`CSU_BYTE_W-1-i];
      return r;
   endfunction : rev8

   function automatic logic [6:0] half_cycles(input logic [3:0] cks);
      logic [6:0] n;
      n = {3'h0, cks} + 7'h01;
      return 7'(n * `CSU_HALF_UNIT);
   endfunction : half_cycles

   function automatic logic [6:0] mon_cycles(input logic [1:0] sel);
      logic [9:0] t;
      t = (sel == 2'h0) ? `CSU_MON_00_TENTHS :
          (sel == 2'h1) ? `CSU_MON_01_TENTHS :
          (sel == 2'h2) ? `CSU_MON_10_TENTHS : `CSU_MON_11_TENTHS;
      return 7'((t + `CSU_TENTHS_PER_CYC - 10'h001) / `CSU_TENTHS_PER_CYC);
   endfunction : mon_cycles

   // state
   csu_st_e    st_q, st_d;
   logic [6:0] cnt_q, cnt_d;
   logic [2:0] bit_q, bit_d;
   csu_byte_t  sh_q, sh_d, tx_hold_q, rx_hold_q, tx_word_q;
   logic       rxm_q, rxm_d, scl_oe_q, scl_oe_d, sda_q, sda_d, sda_oe_q, sda_oe_d;
   logic       tx_empty_q, rx_full_q, lost_q, halt_q, stop_arm_q, dir_q, busy_q;
   logic       tx_req_q, m_load, m_rx_end, halt_set;
   logic       ack_s1_q, ack_s2_q, rxt_s1_q, rxt_s2_q, rxt_s3_q;
   logic       lbit_s1_q, lbit_s2_q, len_s1_q, len_s2_q;
   logic       scl_f, sda_f;
   logic       link_ack, link_rxt, link_bit, link_en;
   csu_byte_t  link_rx;

   // mode decode
   wire        unit_en  = i_ctrl.transfer_enable_bit && i_ctrl.function_select_bit
                          && i_ctrl.format_select;
   wire        mst_en   = unit_en && i_ctrl.clock_master_select;
   wire        ext_en   = unit_en && !i_ctrl.clock_master_select;
   wire        dir_tx   = i_ctrl.direction_select;
   wire        lsb_1st  = i_ctrl.bit_order_select;
   wire [6:0]  half     = half_cycles(i_ctrl.clock_rate_select);
   wire [6:0]  mon      = mon_cycles(i_ctrl.clock_rate_select[`CSU_CKS_MON_HI:`CSU_CKS_MON_LO]);
   wire [6:0]  cnt_inc  = cnt_q + 7'h01;
   wire        dir_rise = dir_tx && !dir_q;
   csu_byte_t  tx_ord;
   assign      tx_ord   = lsb_1st ? rev8(tx_hold_q) : tx_hold_q;

   // slave hand-over and master start decode
   wire        pending  = (tx_req_q != ack_s2_q);
   wire        x_load   = ext_en && dir_tx && dir_q && !tx_empty_q && !pending;
   wire        x_rx_end = ext_en && !dir_tx && (rxt_s2_q != rxt_s3_q);
   wire        tx_move  = m_load || x_load;
   wire        rx_evt   = m_rx_end || x_rx_end;
   csu_byte_t  rx_word;
   assign      rx_word  = m_rx_end ? (lsb_1st ? rev8(sh_q) : sh_q)
                                   : (lsb_1st ? rev8(link_rx) : link_rx);
   wire        start_tx = mst_en && dir_tx && dir_q && !tx_empty_q;
   wire        start_rx = mst_en && !dir_tx && !halt_q;

   // line filters
   csu_filter u_scl_filt (
      .i_mclk  (i_mclk),
      .i_rst_n (i_rst_n),
      .i_pin   (i_pins.scl),
      .o_level (scl_f)
   );
   csu_filter u_sda_filt (
      .i_mclk  (i_mclk),
      .i_rst_n (i_rst_n),
      .i_pin   (i_pins.sda),
      .o_level (sda_f)
   );

   // shifter on the external clock
   csu_link u_link (
      .i_scl_clk (i_scl_clk),
      .i_rst_n   (i_rst_n),
      .i_sda     (i_pins.sda),
      .i_tx_word (tx_word_q),
      .i_tx_req  (tx_req_q),
      .o_tx_ack  (link_ack),
      .o_rx_word (link_rx),
      .o_rx_tgl  (link_rxt),
      .o_sda_bit (link_bit),
      .o_sda_en  (link_en)
   );

   // master engine next state
   always_comb
   begin
      st_d     = st_q;
      cnt_d    = cnt_q;
      bit_d    = bit_q;
      sh_d     = sh_q;
      rxm_d    = rxm_q;
      scl_oe_d = scl_oe_q;
      m_load   = 1'b0;
      m_rx_end = 1'b0;
      halt_set = 1'b0;
      case (st_q)
         ST_IDLE:
         begin
            scl_oe_d = 1'b0;
            cnt_d    = 7'h00;
            bit_d    = `CSU_FIRST_BIT;
            if (start_tx)
            begin
               st_d     = ST_LOW;
               m_load   = 1'b1;
               sh_d     = tx_ord;
               rxm_d    = 1'b0;
               scl_oe_d = 1'b1;
            end
            else if (start_rx)
            begin
               st_d     = ST_LOW;
               rxm_d    = 1'b1;
               scl_oe_d = 1'b1;
            end
         end
         ST_LOW:
         begin
            if (cnt_inc >= half)
            begin
               st_d     = ST_WAIT;
               cnt_d    = 7'h00;
               scl_oe_d = 1'b0;
            end
            else
               cnt_d = cnt_inc;
         end
         ST_WAIT:
         begin
            if (cnt_q < mon)
               cnt_d = cnt_inc;
            else if (scl_f)
            begin
               st_d  = ST_HIGH;
               cnt_d = 7'h00;
               if (rxm_q)
                  sh_d = {sh_q[6:0], sda_f};
            end
         end
         ST_HIGH:
         begin
            if (cnt_inc < half)
               cnt_d = cnt_inc;
            else
            begin
               cnt_d = 7'h00;
               if (bit_q != `CSU_LAST_BIT)
               begin
                  bit_d    = bit_q + 3'h1;
                  st_d     = ST_LOW;
                  scl_oe_d = 1'b1;
                  if (!rxm_q)
                     sh_d = {sh_q[6:0], 1'b0};
               end
               else
               begin
                  bit_d = `CSU_FIRST_BIT;
                  if (rxm_q)
                  begin
                     m_rx_end = 1'b1;
                     if (stop_arm_q)
                     begin
                        st_d     = ST_IDLE;
                        halt_set = 1'b1;
                     end
                     else
                     begin
                        st_d     = ST_LOW;
                        scl_oe_d = 1'b1;
                     end
                  end
                  else if (dir_tx && !tx_empty_q)
                  begin
                     m_load   = 1'b1;
                     sh_d     = tx_ord;
                     st_d     = ST_LOW;
                     scl_oe_d = 1'b1;
                  end
                  else
                     st_d = ST_IDLE;
               end
            end
         end
         default:
         begin
            st_d     = ST_IDLE;
            scl_oe_d = 1'b0;
         end
      endcase
      if (!mst_en)
      begin
         st_d     = ST_IDLE;
         scl_oe_d = 1'b0;
         m_load   = 1'b0;
         m_rx_end = 1'b0;
         halt_set = 1'b0;
      end
   end

   // sda drive select
   always_comb
   begin
      sda_d    = i_ctrl.sda_idle_level;
      sda_oe_d = 1'b0;
      if (mst_en)
      begin
         if (st_d == ST_IDLE)
            sda_oe_d = 1'b1;
         else if (!rxm_d)
         begin
            sda_d    = sh_d[7];
            sda_oe_d = 1'b1;
         end
      end
      else if (ext_en)
      begin
         if (len_s2_q)
         begin
            sda_d    = lbit_s2_q;
            sda_oe_d = 1'b1;
         end
         else if (dir_tx)
            sda_oe_d = 1'b1;
      end
   end

   // engine and pin registers
   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         st_q      <= ST_IDLE;
         cnt_q     <= 7'h00;
         bit_q     <= `CSU_FIRST_BIT;
         sh_q      <= `CSU_BYTE_RST;
         rxm_q     <= 1'b0;
         scl_oe_q  <= 1'b0;
         sda_q     <= `CSU_LINE_RST;
         sda_oe_q  <= 1'b0;
         busy_q    <= 1'b0;
      end
      else
      begin
         st_q      <= st_d;
         cnt_q     <= cnt_d;
         bit_q     <= bit_d;
         sh_q      <= sh_d;
         rxm_q     <= rxm_d;
         scl_oe_q  <= scl_oe_d;
         sda_q     <= sda_d;
         sda_oe_q  <= sda_oe_d;
         busy_q    <= (st_d != ST_IDLE) || len_s2_q;
      end
   end

   // link crossings
   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         ack_s1_q  <= 1'b0;
         ack_s2_q  <= 1'b0;
         rxt_s1_q  <= 1'b0;
         rxt_s2_q  <= 1'b0;
         rxt_s3_q  <= 1'b0;
         lbit_s1_q <= 1'b0;
         lbit_s2_q <= 1'b0;
         len_s1_q  <= 1'b0;
         len_s2_q  <= 1'b0;
         tx_req_q  <= 1'b0;
         tx_word_q <= `CSU_BYTE_RST;
      end
      else
      begin
         ack_s1_q  <= link_ack;
         ack_s2_q  <= ack_s1_q;
         rxt_s1_q  <= link_rxt;
         rxt_s2_q  <= rxt_s1_q;
         rxt_s3_q  <= rxt_s2_q;
         lbit_s1_q <= link_bit;
         lbit_s2_q <= lbit_s1_q;
         len_s1_q  <= link_en;
         len_s2_q  <= len_s1_q;
         if (x_load)
         begin
            tx_word_q <= tx_ord;
            tx_req_q  <= ~tx_req_q;
         end
      end
   end

   // buffer flags and holding registers
   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         tx_hold_q  <= `CSU_BYTE_RST;
         rx_hold_q  <= `CSU_BYTE_RST;
         tx_empty_q <= `CSU_TX_EMPTY_RST;
         rx_full_q  <= 1'b0;
         lost_q     <= 1'b0;
         halt_q     <= 1'b0;
         stop_arm_q <= 1'b0;
         dir_q      <= 1'b0;
      end
      else
      begin
         dir_q <= dir_tx;
         if (i_tx_wr)
            tx_hold_q <= i_tx_data;
         if (dir_rise || tx_move)
            tx_empty_q <= 1'b1;
         else if (i_tx_wr)
            tx_empty_q <= 1'b0;
         if (rx_evt && (!rx_full_q || i_rx_rd))
         begin
            rx_hold_q <= rx_word;
            rx_full_q <= 1'b1;
         end
         else if (i_rx_rd)
            rx_full_q <= 1'b0;
         if (rx_evt && rx_full_q && !i_rx_rd)
            lost_q <= 1'b1;
         else if (i_lost_clr)
            lost_q <= 1'b0;
         if (halt_set)
            stop_arm_q <= 1'b0;
         else if (i_rx_rd && i_ctrl.receive_stop_request && rxm_q)
            stop_arm_q <= 1'b1;
         if (halt_set)
            halt_q <= 1'b1;
         else if (!i_ctrl.receive_stop_request)
            halt_q <= 1'b0;
      end
   end

   // outputs
   assign o_scl_out           = 1'b0 ^ scl_oe_q ^ scl_oe_q;
   assign o_scl_oe            = scl_oe_q;
   assign o_sda_out           = sda_q;
   assign o_sda_oe            = sda_oe_q;
   assign o_tx_buffer_empty   = tx_empty_q;
   assign o_rx_buffer_full    = rx_full_q;
   assign o_lost_overrun_flag = lost_q;
   assign o_rx_data           = rx_hold_q;
   assign o_busy              = busy_q;

   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);

   wr_clears_empty_a : assert property (
      (i_tx_wr && !dir_rise && !tx_move) |=> !o_tx_buffer_empty)
      else $error("transmit write did not clear empty flag");

   dir_sets_empty_a : assert property (
      dir_rise |=> o_tx_buffer_empty)
      else $error("transmit select did not set empty flag");

   move_sets_empty_a : assert property (
      tx_move |=> (o_tx_buffer_empty && (mst_en ? sh_q == $past(tx_ord) : tx_word_q == $past(tx_ord))))
      else $error("holding byte not moved or empty not set");

   read_clears_full_a : assert property (
      (i_rx_rd && !rx_evt) |=> !o_rx_buffer_full)
      else $error("receive read did not clear full flag");

   store_sets_full_a : assert property (
      (rx_evt && (!rx_full_q || i_rx_rd)) |=> (o_rx_buffer_full && o_rx_data == $past(rx_word)))
      else $error("received byte not stored");

   overrun_keeps_a : assert property (
      (rx_evt && rx_full_q && !i_rx_rd) |=> (o_lost_overrun_flag && $stable(o_rx_data)))
      else $error("overrun not flagged or old byte lost");

   idle_level_a : assert property (
      (mst_en && st_d == ST_IDLE) |=> (o_sda_oe && o_sda_out == $past(i_ctrl.sda_idle_level)))
      else $error("idle sda not at idle level");

   slave_release_a : assert property (
      !mst_en |=> !o_scl_oe)
      else $error("scl driven while not clock master");

   monitor_wait_a : assert property (
      (st_q == ST_WAIT && st_d != ST_WAIT && mst_en) |-> (cnt_q == mon))
      else $error("scl sampled before monitor delay");

   sync_stall_a : assert property (
      (st_q == ST_WAIT && mst_en && !scl_f) |=> (st_q == ST_WAIT && !o_scl_oe))
      else $error("high phase began while scl still low");

   halt_high_a : assert property (
      halt_q |-> (!o_scl_oe && st_q == ST_IDLE))
      else $error("scl not parked high after stop");

   master_clock_a : assert property (
      (m_rx_end && !halt_set) |=> (st_q == ST_LOW && o_scl_oe))
      else $error("master receive did not continue clocking");

endmodule : csu_top

// [tb/csu_far.sv]
// Purpose: far clocked serial device on the two lines
// Assumes: scl idles high, pattern sent msb first
// Notes:   drives sda always; the unit's own drive wins
`timescale 1ns/10ps
module csu_far
   import csu_pkg::*;
(
   // line levels
   input  wire logic        i_scl,
   input  wire logic        i_sda,
   // test control
   input  wire logic        i_load,
   input  wire logic        i_stretch,
   input  wire logic [15:0] i_pat,
   // far side drive
   output logic             o_sda,
   output logic             o_scl_hold,
   output logic [15:0]      o_seen
);
   logic [3:0] cnt_q = 4'hF;
   initial
   begin
      o_sda = 1'b1;
      o_scl_hold = 1'b0;
      o_seen = 16'h0000;
   end
   // new bit after each falling scl, restart on load
   always @(negedge i_scl or posedge i_load)
   begin
      if (i_load)
         cnt_q = 4'hF;
      else
      begin
         o_sda = i_pat[cnt_q];
         cnt_q = cnt_q - 4'h1;
      end
   end
   // sample on rising scl
   always @(posedge i_scl) o_seen = {o_seen[14:0], i_sda};
   // hold scl low after each fall
   always @(negedge i_scl)
   begin
      if (i_stretch)
      begin
         o_scl_hold = 1'b1;
         #600 o_scl_hold = 1'b0;
      end
   end
endmodule : csu_far

// [tb/clocked_serial_mode_two_wire_unit_test.sv]
// Purpose: self-checking bench of the clocked serial unit
// Assumes: open-drain lines, rate select 0 except one timed byte
// Notes:   partner pattern alternates two bytes
`timescale 1ns/10ps
module clocked_serial_mode_two_wire_unit_test;
   import csu_pkg::*;
   logic        mclk = 1'b0, rst_n = 1'b0, lclk = 1'b1, tx_wr = 1'b0, rx_rd = 1'b0, lclr = 1'b0;
   logic        ld = 1'b0, str = 1'b0, scl_o, scl_oe, sda_oe, sda_o, tx_e, rx_f, lost, busy, f_sda, hold;
   csu_ctrl_s   ctl = '0;
   csu_byte_t   txd = 8'h00, rxd, b;
   logic [15:0] seen;
   int          bad_count = 0, checked = 0, cyc;
   localparam logic [15:0] PAT = 16'hC35A;
   wire scl = !scl_oe && !hold && lclk;
   wire sda = sda_oe ? sda_o : f_sda;
   always #20 mclk = ~mclk;
   csu_top csu_top_inst (.i_mclk(mclk), .i_rst_n(rst_n), .i_scl_clk(lclk), .i_ctrl(ctl), .i_lost_clr(lclr),
      .i_tx_wr(tx_wr), .i_tx_data(txd), .i_rx_rd(rx_rd), .i_pins({scl, sda}), .o_scl_out(scl_o), .o_scl_oe(scl_oe),
      .o_sda_out(sda_o), .o_sda_oe(sda_oe), .o_tx_buffer_empty(tx_e), .o_rx_buffer_full(rx_f),
      .o_lost_overrun_flag(lost), .o_rx_data(rxd), .o_busy(busy));
   csu_far csu_far_inst (.i_scl(scl), .i_sda(sda), .i_load(ld), .i_stretch(str), .i_pat(PAT),
      .o_sda(f_sda), .o_scl_hold(hold), .o_seen(seen));
   task step;
      @(posedge mclk);
      #2;
   endtask : step
   task chk(input string n, input logic [15:0] s, input logic [15:0] e);
      checked++;
      if (s !== e)
      begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // 0 empty, 1 full, 2 idle, 3 lost
   task await(input int w);
      int n;
      for (n = 0; n < 4000; n++)
      begin
         if ((w == 0 && tx_e === 1'b1) || (w == 1 && rx_f === 1'b1) || (w == 2 && busy === 1'b0)
             || (w == 3 && lost === 1'b1))
            break;
         step;
      end
      chk("wait", n < 4000, 1'b1);
   endtask : await
   task wr(input csu_byte_t d);
      step;
      tx_wr = 1'b1;
      txd = d;
      step;
      tx_wr = 1'b0;
   endtask : wr
   task rd(output csu_byte_t d);
      step;
      d = rxd;
      rx_rd = 1'b1;
      step;
      rx_rd = 1'b0;
   endtask : rd
   function automatic csu_byte_t rev(input csu_byte_t v);
      for (int i = 0; i < 8; i++) rev[i] = v[7 - i];
   endfunction : rev
   task wrap_up;
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : wrap_up
   initial
   begin
      repeat (40000) @(posedge mclk);
      bad_count++;
      wrap_up;
   end
   initial
   begin
      repeat (10) step;
      rst_n = 1'b1;
      chk("reset", {scl_o, scl_oe, sda_oe, tx_e, rx_f, lost, busy, rxd}, 16'h0000);
      ctl.transfer_enable_bit = 1'b1;
      ctl.function_select_bit = 1'b1;
      ctl.format_select = 1'b1;
      step;
      ctl.clock_master_select = 1'b1;
      ctl.direction_select = 1'b1;
      repeat (3) step;
      chk("tx_empty", tx_e, 1'b1);
      chk("sda_idle", {sda_oe, sda_o}, 2'b10);
      ctl.sda_idle_level = 1'b1;
      repeat (3) step;
      chk("sda_idle", {sda_oe, sda_o}, 2'b11);
      for (int o = 0; o < 2; o++)
      begin
         ctl.bit_order_select = o[0];
         wr(8'hA5);
         chk("tx_empty", tx_e, 1'b0);
         await(0);
         wr(8'h3C);
         await(0);
         step;
         await(2);
         chk("tx_pair", seen, o ? {rev(8'hA5), rev(8'h3C)} : 16'hA53C);
      end
      ctl.bit_order_select = 1'b0;
      str = 1'b1;
      wr(8'h96);
      step;
      step;
      await(2);
      chk("stretch", seen[7:0], 8'h96);
      str = 1'b0;
      ctl.clock_rate_select = 4'hC;
      wr(8'h69);
      step;
      for (cyc = 0; busy === 1'b1 && cyc < 2000; cyc++)
         step;
      // 8 bits of 52 low, 43 monitor, 52 high cycles
      chk("rate_cycles", cyc, 16'h0498);
      chk("rate_byte", seen[7:0], 8'h69);
      ctl.clock_rate_select = 4'h0;
      $display("tx done");
      ld = 1'b1;
      step;
      ld = 1'b0;
      ctl.direction_select = 1'b0;
      await(1);
      rd(b);
      chk("rx1", b, PAT[15:8]);
      step;
      chk("rx_full", rx_f, 1'b0);
      await(1);
      rd(b);
      chk("rx2", b, PAT[7:0]);
      await(1);
      await(3);
      chk("lost", {lost, rxd}, {1'b1, PAT[15:8]});
      rd(b);
      lclr = 1'b1;
      step;
      lclr = 1'b0;
      step;
      chk("lost_clr", lost, 1'b0);
      ctl.receive_stop_request = 1'b1;
      await(1);
      rd(b);
      await(1);
      repeat (300) step;
      chk("stop", {scl, busy}, 2'b10);
      ctl.receive_stop_request = 1'b0;
      ctl.clock_master_select = 1'b0;
      rd(b);
      chk("stop_byte", b, PAT[7:0]);
      $display("master rx done");
      ld = 1'b1;
      step;
      ld = 1'b0;
      #7;
      repeat (8)
      begin
         lclk = 1'b0;
         #16 lclk = 1'b1;
         #16;
      end
      await(1);
      rd(b);
      chk("slave_rx", {scl_oe, b}, {1'b0, PAT[15:8]});
      $display("slave rx done");
      wrap_up;
   end
endmodule : clocked_serial_mode_two_wire_unit_test
